//--- rtl/amx_decode.sv
// opcode classifier for the three exchange instructions
// assumes a 10-bit instruction word from fetch
`default_nettype none
module amx_decode
  import amx_pkg::*;
(
  input  wire logic [9:0] i_instr, // instruction word
  output amx_op_e         o_op     // decoded class
);
  always_comb begin
    case (i_instr[9:4])
      AMX_OP_SWAP:     o_op = AMX_SWAP;
      AMX_OP_SWAP_DEC: o_op = AMX_DEC;
      AMX_OP_SWAP_INC: o_op = AMX_INC; // RULE7
      default:         o_op = AMX_NONE;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/amx_exec.sv
// execution of the accumulator / memory swap instructions
// assumes the nibble ram answers combinationally at the pointed address
`default_nettype none
module amx_exec
  import amx_pkg::*;
(
  input  wire logic       i_clk,         // system clock
  input  wire logic       i_reset_n,     // async reset, low
  input  wire logic       i_instr_valid, // instruction word valid this cycle
  input  wire logic [9:0] i_instr,       // instruction word
  input  wire logic [3:0] i_ram_rdata,   // pointed_ram_nibble read data
  input  wire logic       i_carry_flag,  // carry_flag from core
  output logic            o_ram_we,      // write pointed nibble
  output logic      [3:0] o_ram_wdata,   // write data
  output logic      [1:0] o_page,        // data_pointer page
  output logic      [3:0] o_row,         // data_pointer row
  output logic      [3:0] o_col,         // data_pointer column
  output logic      [3:0] o_acc,         // accumulator
  output logic            o_carry_flag,  // carry_flag, passed unchanged
  output logic            o_skip         // current instruction executes as nop
);
  typedef struct packed {
    logic [3:0] acc;
    logic [1:0] page;
    logic [3:0] row;
    logic [3:0] col;
    logic       we;
    logic [3:0] wdata;
    logic       skip;
    logic       cy;
    logic [1:0] wr_page; // pointer that the pending ram write belongs to
    logic [3:0] wr_row;
    logic [3:0] wr_col;
  } amx_state_s;

  localparam amx_state_s AMX_ST_RST = '{acc: AMX_NIB_RST, page: AMX_PAGE_RST, row: AMX_NIB_RST,
                                        col: AMX_NIB_RST, default: '0};

  amx_state_s st_r, st_nxt;
  amx_op_e    op;
  logic       exec;
  logic       swap;    // an exchange executes this cycle
  logic       fwd;     // pending ram write targets the current pointer
  amx_nib_t   mem_nib; // pointed nibble as the program sees it

  amx_decode u_dec (
    .i_instr (i_instr),
    .o_op    (op)
  );

  // a skipped word is still fetched but must not execute
  assign exec = i_instr_valid && !st_r.skip; // RULE8
  assign swap = exec && (op != AMX_NONE);
  // ram write lands two edges after its swap; a swap on the next word at the same
  // pointer would otherwise read the stale nibble, so the pending data is used
  assign fwd     = st_r.we && ({st_r.wr_page, st_r.wr_row, st_r.wr_col} == {st_r.page, st_r.row, st_r.col});
  assign mem_nib = fwd ? st_r.wdata : i_ram_rdata;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.we = 1'b0;
    st_nxt.cy = i_carry_flag; // RULE8
    if (i_instr_valid) st_nxt.skip = 1'b0;
    if (exec && op != AMX_NONE) begin
      st_nxt.we    = 1'b1;                       // RULE1
      st_nxt.wdata = st_r.acc;                   // RULE1
      st_nxt.acc   = mem_nib;                    // RULE1
      st_nxt.wr_page = st_r.page;
      st_nxt.wr_row  = st_r.row;
      st_nxt.wr_col  = st_r.col;
      st_nxt.row   = st_r.row ^ i_instr[3:0];    // RULE2
      case (op)
        AMX_DEC: begin
          st_nxt.col  = st_r.col - 4'h1;                        // RULE3
          st_nxt.skip = (st_nxt.col == AMX_COL_DEC_WRAP);       // RULE4
        end
        AMX_INC: begin
          st_nxt.col  = st_r.col + 4'h1;                        // RULE5
          st_nxt.skip = (st_nxt.col == AMX_COL_INC_WRAP);       // RULE6
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= AMX_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ram_we     = st_r.we;
  assign o_ram_wdata  = st_r.wdata;
  assign o_page       = st_r.page;
  assign o_row        = st_r.row;
  assign o_col        = st_r.col;
  assign o_acc        = st_r.acc;
  assign o_carry_flag = st_r.cy;
  assign o_skip       = st_r.skip;

  swap_value_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE1
    exec && op != AMX_NONE |=> o_acc == $past(mem_nib) && o_ram_wdata == $past(st_r.acc) && o_ram_we)
    else $error("swap values wrong");
  row_xor_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE2
    exec && op != AMX_NONE |=> o_row == ($past(st_r.row) ^ $past(i_instr[3:0])))
    else $error("row xor wrong");
  col_dec_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE3
    exec && op == AMX_DEC |=> o_col == $past(st_r.col) - 4'h1)
    else $error("column decrement wrong");
  dec_skip_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE4
    exec && op == AMX_DEC |=> o_skip == (o_col == 4'hf))
    else $error("decrement skip wrong");
  col_inc_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE5
    exec && op == AMX_INC |=> o_col == $past(st_r.col) + 4'h1)
    else $error("column increment wrong");
  inc_skip_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE6
    exec && op == AMX_INC |=> o_skip == (o_col == 4'h0))
    else $error("increment skip wrong");
  inc_decode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE7
    (i_instr[9:4] == 6'h2e) |-> op == AMX_INC)
    else $error("increment decode wrong");
  skipped_nop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE8
    o_skip && i_instr_valid |=> !o_ram_we && $stable(o_acc) && $stable(o_col) && $stable(o_row))
    else $error("skipped word executed");
  fwd_data_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE1
    swap && fwd |=> o_acc == $past(st_r.wdata))
    else $error("pending write not forwarded");
  we_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE1
    !swap |=> !o_ram_we)
    else $error("ram write without a swap");
  plain_col_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE1
    exec && op == AMX_SWAP |=> $stable(o_col) && !o_skip)
    else $error("plain swap moved column");
  carry_pass_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE8
    1'b1 |=> o_carry_flag == $past(i_carry_flag))
    else $error("carry flag altered");
  skip_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE8
    o_skip && i_instr_valid |=> !o_skip)
    else $error("skip not cleared by consumed word");
  foreign_word_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE8
    exec && op == AMX_NONE |=> !o_ram_we && !o_skip && $stable(o_acc) && $stable(o_row) && $stable(o_col))
    else $error("foreign word changed state");
endmodule
`default_nettype wire

//--- rtl/amx_pkg.sv
// constants for the accumulator / memory exchange execution block
// assumes a single clock, one instruction presented per cycle by fetch
// What this block does
// RULE1: plain swap exchanges accumulator and pointed nibble
// RULE2: row register xored with 4-bit immediate
// RULE3: decrement variant lowers column modulo sixteen
// RULE4: decrement wrap to 15 skips next
// RULE5: increment variant raises column modulo sixteen
// RULE6: increment wrap to 0 skips next
// RULE7: increment opcode upper six bits 101110
// RULE8: one word, one cycle, carry untouched
`default_nettype none
package amx_pkg;
  localparam logic [5:0] AMX_OP_SWAP     = 6'h2d; // 101101
  localparam logic [5:0] AMX_OP_SWAP_DEC = 6'h2f; // 101111
  localparam logic [5:0] AMX_OP_SWAP_INC = 6'h2e; // 101110
  localparam logic [3:0] AMX_COL_DEC_WRAP = 4'hf;
  localparam logic [3:0] AMX_COL_INC_WRAP = 4'h0;
  localparam logic [3:0] AMX_NIB_RST     = 4'h0;
  localparam logic [1:0] AMX_PAGE_RST    = 2'h0;
  typedef enum logic [1:0] {AMX_NONE, AMX_SWAP, AMX_DEC, AMX_INC} amx_op_e;
  typedef logic [3:0] amx_nib_t;
endpackage
`default_nettype wire

//--- testbench/acc_mem_exchange_exec_test.sv
// self-checking bench for the exchange execution block
// assumes amx_ram_model answers reads combinationally
`default_nettype none
module acc_mem_exchange_exec_test;
  import amx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0, i_reset_n = 0, i_instr_valid = 0, i_carry_flag = 0;
  logic       o_ram_we, o_carry_flag, o_skip;
  logic [9:0] i_instr = 10'h000;
  logic [3:0] i_ram_rdata, o_ram_wdata, o_row, o_col, o_acc, ea = 4'h0, er = 4'h0, ec = 4'h0;
  logic [1:0] o_page;
  logic [3:0] sh [1024];
  int         mismatches = 0, num_checks = 0;
  always #2 i_clk = ~i_clk;
  initial for (int i = 0; i < 1024; i++) sh[i] = 4'(i * 7);
  amx_exec DUT (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_instr_valid (i_instr_valid),
    .i_instr       (i_instr),
    .i_ram_rdata   (i_ram_rdata),
    .i_carry_flag  (i_carry_flag),
    .o_ram_we      (o_ram_we),
    .o_ram_wdata   (o_ram_wdata),
    .o_page        (o_page),
    .o_row         (o_row),
    .o_col         (o_col),
    .o_acc         (o_acc),
    .o_carry_flag  (o_carry_flag),
    .o_skip        (o_skip)
  );
  amx_ram_model ram (
    .i_clk   (i_clk),
    .i_addr  ({o_page, o_row, o_col}),
    .i_we    (o_ram_we),
    .i_wdata (o_ram_wdata),
    .o_rdata (i_ram_rdata)
  );
  task chk(input string n, input logic [3:0] e, input logic [3:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task op(input logic [5:0] o, input logic [3:0] j);
    logic [3:0] a;
    logic       sk;
    a = ea;
    ea = sh[{2'h0, er, ec}];
    sh[{2'h0, er, ec}] = a;
    er ^= j;
    if (o == AMX_OP_SWAP_DEC) ec--;
    if (o == AMX_OP_SWAP_INC) ec++;
    sk = (o == AMX_OP_SWAP_DEC && ec == 4'hf) || (o == AMX_OP_SWAP_INC && ec == 4'h0);
    @(posedge i_clk) {i_instr_valid, i_instr, i_carry_flag} <= {1'b1, o, j, j[0]};
    @(posedge i_clk) i_instr_valid <= 0;
    #1 chk("acc", ea, o_acc);
    chk("wdata", a, o_ram_wdata);
    chk("row", er, o_row);
    chk("col", ec, o_col);
    chk("we skip", {2'h0, 1'b1, sk}, {2'h0, o_ram_we, o_skip});
    chk("carry", {3'h0, j[0]}, {3'h0, o_carry_flag});
    chk("page", 4'h0, {2'h0, o_page});
    @(posedge i_clk);
    #1 chk("we off", 4'h0, {3'h0, o_ram_we});
  endtask
  // skipped or foreign word must leave acc, row and column alone, with skip and write strobe low after it
  task idle_word(input logic [9:0] w);
    @(posedge i_clk) {i_instr_valid, i_instr} <= {1'b1, w};
    @(posedge i_clk) i_instr_valid <= 0;
    #1 chk("acc", ea, o_acc);
    chk("skip we", 4'h0, {2'h0, o_skip, o_ram_we});
    chk("row", er, o_row);
    chk("col", ec, o_col);
  endtask
  task t_swap;
    op(AMX_OP_SWAP, 4'ha);
    op(AMX_OP_SWAP, 4'hf);
  endtask
  task t_dec;
    op(AMX_OP_SWAP_DEC, 4'h3);
    idle_word({AMX_OP_SWAP, 4'h0});
    op(AMX_OP_SWAP_DEC, 4'h0);
  endtask
  task t_inc;
    op(AMX_OP_SWAP_INC, 4'h5);
    op(AMX_OP_SWAP_INC, 4'h6);
    idle_word({AMX_OP_SWAP_INC, 4'h1});
    idle_word({6'h2c, 4'h5});
  endtask
  // two swaps on consecutive words at one pointer: the second must see the first's write
  task t_back;
    logic [3:0] m;
    m = sh[{2'h0, er, ec}];
    @(posedge i_clk) {i_instr_valid, i_instr} <= {1'b1, AMX_OP_SWAP, 4'h0};
    @(posedge i_clk);
    #1 chk("acc", m, o_acc);
    @(posedge i_clk) i_instr_valid <= 1'b0;
    #1 chk("acc", ea, o_acc);
    chk("wdata", m, o_ram_wdata);
    chk("we", 4'h1, {3'h0, o_ram_we});
    op(AMX_OP_SWAP, 4'h0);
  endtask
  // mid-run reset clears every register; ram keeps its contents, so the shadow does too
  task t_reset;
    @(posedge i_clk) {i_reset_n, i_carry_flag} <= 2'b00;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    {ea, er, ec} = 12'h000;
    #1 chk("acc", 4'h0, o_acc);
    chk("row", 4'h0, o_row);
    chk("col", 4'h0, o_col);
    chk("page", 4'h0, {2'h0, o_page});
    chk("we skip carry", 4'h0, {1'h0, o_ram_we, o_skip, o_carry_flag});
    op(AMX_OP_SWAP_INC, 4'h1);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1;
    t_swap();
    t_dec();
    t_inc();
    t_back();
    t_reset();
    complete_run();
  end
  initial begin
    #4000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire

//--- testbench/amx_ram_model.sv
// nibble ram model on the far side of the exec block
// assumes the write address is the pointer seen one edge before o_ram_we
`default_nettype none
module amx_ram_model (
  input  wire logic       i_clk,   // clock
  input  wire logic [9:0] i_addr,  // page, row, column
  input  wire logic       i_we,    // write strobe
  input  wire logic [3:0] i_wdata, // write data
  output logic      [3:0] o_rdata  // pointed nibble
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [1024];
  logic [9:0] addr_r;
  initial for (int i = 0; i < 1024; i++) mem[i] = 4'(i * 7);
  assign o_rdata = mem[i_addr];
  always @(posedge i_clk) begin
    addr_r <= i_addr;
    if (i_we) mem[addr_r] <= i_wdata;
  end
endmodule
`default_nettype wire
